// file: phm_cfg.svh
`ifndef PHM_CFG_SVH
`define PHM_CFG_SVH

`define PHM_ADDR_ROLE      32'h5600_0070
`define PHM_ADDR_DATA      32'h5600_0074
`define PHM_ADDR_PULL      32'h5600_0078
`define PHM_ADDR_RSVD      32'h5600_007C
`define PHM_ADDR_MISC      32'h5600_0080
`define PHM_ADDR_DCLK      32'h5600_0084

`define PHM_NPIN           11
`define PHM_ROLE_W         22
`define PHM_RST_ROLE       22'h00_0000
`define PHM_RST_PULL       11'h000
`define PHM_RST_MISC       32'h0001_0330
`define PHM_RST_DCLK       32'h0000_0000
`define PHM_MASK_MISC      32'h000F_377B
`define PHM_MASK_DCLK      32'h0FF3_0FF3
`define PHM_ZERO32         32'h0000_0000

`define PHM_MISC_CKE_OFF   19
`define PHM_MISC_CK1_OFF   18
`define PHM_MISC_CK0_OFF   17
`define PHM_MISC_RST_LVL   16
`define PHM_MISC_USB1_SUSP 13
`define PHM_MISC_USB0_SUSP 12
`define PHM_MISC_SEL1_HI   10
`define PHM_MISC_SEL1_LO   8
`define PHM_MISC_SEL0_HI   6
`define PHM_MISC_SEL0_LO   4
`define PHM_MISC_USB_HOST  3
`define PHM_MISC_DLO_PUOFF 1
`define PHM_MISC_DHI_PUOFF 0

`define PHM_DCLK_FIELD_W   16
`define PHM_DCLK_CMP_HI    11
`define PHM_DCLK_CMP_LO    8
`define PHM_DCLK_DIV_HI    7
`define PHM_DCLK_DIV_LO    4
`define PHM_DCLK_SEL       1
`define PHM_DCLK_EN        0

`define PHM_PIN_CTS0       0
`define PHM_PIN_RTS0       1
`define PHM_PIN_SERIAL0_TRANSMIT       2
`define PHM_PIN_SERIAL0_RECEIVE       3
`define PHM_PIN_SERIAL1_TRANSMIT       4
`define PHM_PIN_SERIAL1_RECEIVE       5
`define PHM_PIN_SERIAL2_TRANSMIT       6
`define PHM_PIN_SERIAL2_RECEIVE       7
`define PHM_PIN_UEXT       8
`define PHM_PIN_CLKO0      9
`define PHM_PIN_CLKO1      10

`endif

// file: phm_pkg.sv
package phm_pkg;

  typedef enum logic [1:0]
  {
    PHM_ROLE_IN   = 2'h0,
    PHM_ROLE_OUT  = 2'h1,
    PHM_ROLE_ALT1 = 2'h2,
    PHM_ROLE_ALT2 = 2'h3
  } phm_role_e;

  typedef enum logic [2:0]
  {
    PHM_SRC_MAIN_PLL = 3'h0,
    PHM_SRC_USB_PLL = 3'h1,
    PHM_SRC_CORE = 3'h2,
    PHM_SRC_BUS  = 3'h3,
    PHM_SRC_PER  = 3'h4,
    PHM_SRC_DIV  = 3'h5
  } phm_src_e;

endpackage

// file: phm_port_misc.sv
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ps
`include "phm_cfg.svh"
module phm_port_misc
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [31:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Port pins
  input  wire logic [10:0] pin_in_i,
  output logic      [10:0] pin_out_o,
  output logic      [10:0] pin_oe_n_o,
  output logic      [10:0] pin_pullup_off_o,
  // Serial peripheral side
  input  wire logic        serial0_transmit_i,
  input  wire logic        serial1_transmit_i,
  input  wire logic        serial2_transmit_i,
  input  wire logic        serial0_request_to_send_i,
  input  wire logic        serial1_request_to_send_i,
  output logic             serial0_receive_o,
  output logic             serial1_receive_o,
  output logic             serial2_receive_o,
  output logic             serial0_clear_to_send_o,
  output logic             serial1_clear_to_send_o,
  output logic             serial_external_clock_o,
  // Monitored clock sources
  input  wire logic        main_pll_i,
  input  wire logic        usb_pll_i,
  input  wire logic        core_clock_i,
  input  wire logic        bus_clock_i,
  input  wire logic        usb_clock_i,
  // Memory clock path
  input  wire logic        mem_clock_i,
  input  wire logic        mem_clock_enable_i,
  output logic             mem_clock0_out_o,
  output logic             mem_clock1_out_o,
  output logic             mem_clock_enable_out_o,
  // Miscellaneous controls
  output logic             external_reset_out_o,
  output logic             usb_port0_suspend_o,
  output logic             usb_port1_suspend_o,
  output logic             usb_pad_owner_sel_o,
  output logic             data_low_pullup_off_o,
  output logic             data_high_pullup_off_o
);

  logic [21:0] role_r;
  logic [10:0] data_r;
  logic [10:0] pull_r;
  logic [31:0] misc_r;
  logic [31:0] dclk_reg_r;
  logic        ack_r;
  logic [31:0] dat_r;
  logic [10:0] pin_s1_r;
  logic [10:0] pin_s2_r;
  logic [4:0]  src_s1_r;
  logic [4:0]  src_s2_r;
  logic        usb_prev_r;
  logic        per_half_r;
  logic [3:0]  cnt_r [2];
  logic [1:0]  dclk_r;
  logic        clk_out0_r;
  logic        clk_out1_r;
  logic [10:0] pin_out_nxt;
  logic [10:0] pin_oe_n_nxt;
  logic [10:0] pin_out_r;
  logic [10:0] pin_oe_n_r;
  logic [31:0] rd_nxt;
  logic        wr_en;
  logic        usb_tick;

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
        res[b*8 +: 8] = new_v[b*8 +: 8];
    end
    return res;
  endfunction

  function automatic logic [2:0] src_sel(input logic [31:0] m, input logic hi);
    logic [2:0] s;
    s = hi ? m[`PHM_MISC_SEL1_HI:`PHM_MISC_SEL1_LO] : m[`PHM_MISC_SEL0_HI:`PHM_MISC_SEL0_LO];
    return s;
  endfunction

  // Bus handshake: one wait state, ack for a single cycle
  assign wr_en = cyc_i && stb_i && we_i && ack_r;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_r <= 1'b0;
    else
      ack_r <= cyc_i && stb_i && !ack_r;
  end

  // Input synchronisers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_s1_r   <= `PHM_RST_PULL;
      pin_s2_r   <= `PHM_RST_PULL;
      src_s1_r   <= 5'h00;
      src_s2_r   <= 5'h00;
      usb_prev_r <= 1'b0;
    end
    else
    begin
      pin_s1_r   <= pin_in_i;
      pin_s2_r   <= pin_s1_r;
      src_s1_r   <= {usb_clock_i, bus_clock_i, core_clock_i, usb_pll_i, main_pll_i};
      src_s2_r   <= src_s1_r;
      usb_prev_r <= src_s2_r[4];
    end
  end

  assign usb_tick = src_s2_r[4] && !usb_prev_r;

  // Register writes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      role_r     <= `PHM_RST_ROLE;
      data_r     <= `PHM_RST_PULL;
      pull_r     <= `PHM_RST_PULL;
      misc_r     <= `PHM_RST_MISC;
      dclk_reg_r <= `PHM_RST_DCLK;
    end
    else if (wr_en)
    begin
      if (adr_i == `PHM_ADDR_ROLE)
        role_r <= `PHM_ROLE_W'(merge({10'h000, role_r}, dat_i, sel_i));
      else if (adr_i == `PHM_ADDR_DATA)
        data_r <= `PHM_NPIN'(merge({21'h00_0000, data_r}, dat_i, sel_i));
      else if (adr_i == `PHM_ADDR_PULL)
        pull_r <= `PHM_NPIN'(merge({21'h00_0000, pull_r}, dat_i, sel_i));
      else if (adr_i == `PHM_ADDR_MISC)
        misc_r <= merge(misc_r, dat_i, sel_i) & `PHM_MASK_MISC;
      else if (adr_i == `PHM_ADDR_DCLK)
        dclk_reg_r <= merge(dclk_reg_r, dat_i, sel_i) & `PHM_MASK_DCLK;
    end
  end

  // Read mux; alternate pins read the synchronised pin level
  always_comb
  begin
    rd_nxt = `PHM_ZERO32;
    if (adr_i == `PHM_ADDR_ROLE)
      rd_nxt = {10'h000, role_r};
    else if (adr_i == `PHM_ADDR_DATA)
    begin
      for (int i = 0; i < `PHM_NPIN; i++)
      begin
        if (phm_pkg::phm_role_e'(role_r[2*i +: 2]) == phm_pkg::PHM_ROLE_OUT)
          rd_nxt[i] = data_r[i];
        else
          rd_nxt[i] = pin_s2_r[i];
      end
    end
    else if (adr_i == `PHM_ADDR_PULL)
      rd_nxt = {21'h00_0000, pull_r};
    else if (adr_i == `PHM_ADDR_MISC)
      rd_nxt = misc_r;
    else if (adr_i == `PHM_ADDR_DCLK)
      rd_nxt = dclk_reg_r;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_r <= `PHM_ZERO32;
    else if (cyc_i && stb_i && !we_i && !ack_r)
      dat_r <= rd_nxt;
  end

  // Peripheral clock monitor at half rate
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      per_half_r <= 1'b0;
    else
      per_half_r <= !per_half_r;
  end

  // Divided clock generators
  for (genvar g = 0; g < 2; g++)
  begin : g_div
    logic [15:0] fld;
    logic [3:0]  cmp;
    logic [3:0]  div;
    logic        en;
    logic        tick;
    logic [3:0]  cnt_nxt;

    assign fld  = dclk_reg_r[g*`PHM_DCLK_FIELD_W +: `PHM_DCLK_FIELD_W];
    assign cmp  = fld[`PHM_DCLK_CMP_HI:`PHM_DCLK_CMP_LO];
    assign div  = fld[`PHM_DCLK_DIV_HI:`PHM_DCLK_DIV_LO];
    assign en   = fld[`PHM_DCLK_EN];
    assign tick = fld[`PHM_DCLK_SEL] ? usb_tick : 1'b1;

    always_comb
    begin
      cnt_nxt = cnt_r[g];
      if (!en)
        cnt_nxt = 4'h0;
      else if (tick)
        cnt_nxt = (cnt_r[g] == div) ? 4'h0 : cnt_r[g] + 4'h1;
    end

    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        cnt_r[g]  <= 4'h0;
        dclk_r[g] <= 1'b0;
      end
      else
      begin
        cnt_r[g]  <= cnt_nxt;
        dclk_r[g] <= en && (cnt_nxt > cmp);
      end
    end

    a_div_idle_low : assert property (@(posedge clk_i) disable iff (rst_i)
      !en |=> !dclk_r[g] && cnt_r[g] == 4'h0)
      else $error("disabled divider not idle");
    a_div_wrap_low : assert property (@(posedge clk_i) disable iff (rst_i)
      en && !fld[`PHM_DCLK_SEL] && cnt_r[g] == div && $stable(fld)
      |=> cnt_r[g] == 4'h0 && !dclk_r[g])
      else $error("divider did not wrap to low phase");
    a_div_high_edge : assert property (@(posedge clk_i) disable iff (rst_i)
      en && !fld[`PHM_DCLK_SEL] && cnt_r[g] == cmp && cmp < div
      |=> dclk_r[g])
      else $error("divider high phase late");
  end

  // Clock output source selection
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      clk_out0_r <= 1'b0;
      clk_out1_r <= 1'b0;
    end
    else
    begin
      for (int k = 0; k < 2; k++)
      begin
        logic o;
        o = 1'b0;
        case (phm_pkg::phm_src_e'(src_sel(misc_r, k[0])))
          phm_pkg::PHM_SRC_MAIN_PLL: o = src_s2_r[0];
          phm_pkg::PHM_SRC_USB_PLL: o = src_s2_r[1];
          phm_pkg::PHM_SRC_CORE: o = src_s2_r[2];
          phm_pkg::PHM_SRC_BUS:  o = src_s2_r[3];
          phm_pkg::PHM_SRC_PER:  o = per_half_r;
          phm_pkg::PHM_SRC_DIV:  o = dclk_r[k];
          default:               o = 1'b0;
        endcase
        if (k == 0)
          clk_out0_r <= o;
        else
          clk_out1_r <= o;
      end
    end
  end

  // Pin drive per role
  always_comb
  begin
    pin_out_nxt  = `PHM_RST_PULL;
    pin_oe_n_nxt = ~`PHM_RST_PULL;
    for (int i = 0; i < `PHM_NPIN; i++)
    begin
      if (phm_pkg::phm_role_e'(role_r[2*i +: 2]) == phm_pkg::PHM_ROLE_OUT)
      begin
        pin_out_nxt[i]  = data_r[i];
        pin_oe_n_nxt[i] = 1'b0;
      end
    end
    if (phm_pkg::phm_role_e'(role_r[2*`PHM_PIN_RTS0 +: 2]) == phm_pkg::PHM_ROLE_ALT1)
    begin
      pin_out_nxt[`PHM_PIN_RTS0]  = serial0_request_to_send_i;
      pin_oe_n_nxt[`PHM_PIN_RTS0] = 1'b0;
    end
    if (phm_pkg::phm_role_e'(role_r[2*`PHM_PIN_SERIAL0_TRANSMIT +: 2]) == phm_pkg::PHM_ROLE_ALT1)
    begin
      pin_out_nxt[`PHM_PIN_SERIAL0_TRANSMIT]  = serial0_transmit_i;
      pin_oe_n_nxt[`PHM_PIN_SERIAL0_TRANSMIT] = 1'b0;
    end
    if (phm_pkg::phm_role_e'(role_r[2*`PHM_PIN_SERIAL1_TRANSMIT +: 2]) == phm_pkg::PHM_ROLE_ALT1)
    begin
      pin_out_nxt[`PHM_PIN_SERIAL1_TRANSMIT]  = serial1_transmit_i;
      pin_oe_n_nxt[`PHM_PIN_SERIAL1_TRANSMIT] = 1'b0;
    end
    if (phm_pkg::phm_role_e'(role_r[2*`PHM_PIN_SERIAL2_TRANSMIT +: 2]) == phm_pkg::PHM_ROLE_ALT1)
    begin
      pin_out_nxt[`PHM_PIN_SERIAL2_TRANSMIT]  = serial2_transmit_i;
      pin_oe_n_nxt[`PHM_PIN_SERIAL2_TRANSMIT] = 1'b0;
    end
    else if (phm_pkg::phm_role_e'(role_r[2*`PHM_PIN_SERIAL2_TRANSMIT +: 2]) == phm_pkg::PHM_ROLE_ALT2)
    begin
      pin_out_nxt[`PHM_PIN_SERIAL2_TRANSMIT]  = serial1_request_to_send_i;
      pin_oe_n_nxt[`PHM_PIN_SERIAL2_TRANSMIT] = 1'b0;
    end
    if (phm_pkg::phm_role_e'(role_r[2*`PHM_PIN_CLKO0 +: 2]) == phm_pkg::PHM_ROLE_ALT1)
    begin
      pin_out_nxt[`PHM_PIN_CLKO0]  = clk_out0_r;
      pin_oe_n_nxt[`PHM_PIN_CLKO0] = 1'b0;
    end
    if (phm_pkg::phm_role_e'(role_r[2*`PHM_PIN_CLKO1 +: 2]) == phm_pkg::PHM_ROLE_ALT1)
    begin
      pin_out_nxt[`PHM_PIN_CLKO1]  = clk_out1_r;
      pin_oe_n_nxt[`PHM_PIN_CLKO1] = 1'b0;
    end
  end

  // Registered pin and peripheral outputs; idle receive and clear-to-send inputs read high, idle external clock low
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_out_r               <= `PHM_RST_PULL;
      pin_oe_n_r              <= ~`PHM_RST_PULL;
      serial0_receive_o       <= 1'b1;
      serial1_receive_o       <= 1'b1;
      serial2_receive_o       <= 1'b1;
      serial0_clear_to_send_o <= 1'b1;
      serial1_clear_to_send_o <= 1'b1;
      serial_external_clock_o <= 1'b0;
    end
    else
    begin
      pin_out_r  <= pin_out_nxt;
      pin_oe_n_r <= pin_oe_n_nxt;
      serial0_clear_to_send_o <= (phm_pkg::phm_role_e'(role_r[2*`PHM_PIN_CTS0 +: 2])
        == phm_pkg::PHM_ROLE_ALT1) ? pin_s2_r[`PHM_PIN_CTS0] : 1'b1;
      serial0_receive_o <= (phm_pkg::phm_role_e'(role_r[2*`PHM_PIN_SERIAL0_RECEIVE +: 2])
        == phm_pkg::PHM_ROLE_ALT1) ? pin_s2_r[`PHM_PIN_SERIAL0_RECEIVE] : 1'b1;
      serial1_receive_o <= (phm_pkg::phm_role_e'(role_r[2*`PHM_PIN_SERIAL1_RECEIVE +: 2])
        == phm_pkg::PHM_ROLE_ALT1) ? pin_s2_r[`PHM_PIN_SERIAL1_RECEIVE] : 1'b1;
      serial2_receive_o <= (phm_pkg::phm_role_e'(role_r[2*`PHM_PIN_SERIAL2_RECEIVE +: 2])
        == phm_pkg::PHM_ROLE_ALT1) ? pin_s2_r[`PHM_PIN_SERIAL2_RECEIVE] : 1'b1;
      serial1_clear_to_send_o <= (phm_pkg::phm_role_e'(role_r[2*`PHM_PIN_SERIAL2_RECEIVE +: 2])
        == phm_pkg::PHM_ROLE_ALT2) ? pin_s2_r[`PHM_PIN_SERIAL2_RECEIVE] : 1'b1;
      serial_external_clock_o <= (phm_pkg::phm_role_e'(role_r[2*`PHM_PIN_UEXT +: 2])
        == phm_pkg::PHM_ROLE_ALT1) ? pin_s2_r[`PHM_PIN_UEXT] : 1'b0;
    end
  end

  // Miscellaneous outputs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mem_clock0_out_o       <= 1'b0;
      mem_clock1_out_o       <= 1'b0;
      mem_clock_enable_out_o <= 1'b0;
      external_reset_out_o   <= 1'b1;
      usb_port0_suspend_o    <= 1'b0;
      usb_port1_suspend_o    <= 1'b0;
      usb_pad_owner_sel_o    <= 1'b0;
      data_low_pullup_off_o  <= 1'b0;
      data_high_pullup_off_o <= 1'b0;
      pin_pullup_off_o       <= `PHM_RST_PULL;
    end
    else
    begin
      mem_clock_enable_out_o <= mem_clock_enable_i && !misc_r[`PHM_MISC_CKE_OFF];
      mem_clock1_out_o       <= mem_clock_i && !misc_r[`PHM_MISC_CK1_OFF];
      mem_clock0_out_o       <= mem_clock_i && !misc_r[`PHM_MISC_CK0_OFF];
      external_reset_out_o   <= misc_r[`PHM_MISC_RST_LVL];
      usb_port1_suspend_o    <= misc_r[`PHM_MISC_USB1_SUSP];
      usb_port0_suspend_o    <= misc_r[`PHM_MISC_USB0_SUSP];
      usb_pad_owner_sel_o    <= misc_r[`PHM_MISC_USB_HOST];
      data_low_pullup_off_o  <= misc_r[`PHM_MISC_DLO_PUOFF];
      data_high_pullup_off_o <= misc_r[`PHM_MISC_DHI_PUOFF];
      pin_pullup_off_o       <= pull_r;
    end
  end

  assign ack_o      = ack_r;
  assign dat_o      = dat_r;
  assign pin_out_o  = pin_out_r;
  assign pin_oe_n_o = pin_oe_n_r;

  a_input_release : assert property (@(posedge clk_i) disable iff (rst_i)
    role_r[1:0] == 2'h0 |=> pin_oe_n_o[0])
    else $error("input pin 0 driven");
  a_output_drive : assert property (@(posedge clk_i) disable iff (rst_i)
    role_r[1:0] == 2'h1 |=> !pin_oe_n_o[0] && pin_out_o[0] == $past(data_r[0]))
    else $error("output pin 0 not driven from data");
  a_input_read : assert property (@(posedge clk_i) disable iff (rst_i)
    cyc_i && stb_i && !we_i && !ack_r && adr_i == `PHM_ADDR_DATA && role_r[1:0] == 2'h0
    |=> ack_o && dat_o[0] == $past(pin_s2_r[0]))
    else $error("input read mismatch");
  a_mem_force_low : assert property (@(posedge clk_i) disable iff (rst_i)
    misc_r[`PHM_MISC_CKE_OFF] && misc_r[`PHM_MISC_CK0_OFF]
    |=> !mem_clock_enable_out_o && !mem_clock0_out_o)
    else $error("memory clock not forced low");
  a_reset_level : assert property (@(posedge clk_i) disable iff (rst_i)
    wr_en && adr_i == `PHM_ADDR_MISC && sel_i[2]
    |=> ##1 external_reset_out_o == $past(dat_i[`PHM_MISC_RST_LVL], 2))
    else $error("reset output level wrong");
  a_pullup_write : assert property (@(posedge clk_i) disable iff (rst_i)
    wr_en && adr_i == `PHM_ADDR_PULL && sel_i[0]
    |=> ##1 pin_pullup_off_o[0] == $past(dat_i[0], 2))
    else $error("pull-up control not applied");
  a_clkout_div : assert property (@(posedge clk_i) disable iff (rst_i)
    misc_r[`PHM_MISC_SEL0_HI:`PHM_MISC_SEL0_LO] == 3'h5 && $stable(misc_r)
    |=> clk_out0_r == $past(dclk_r[0]))
    else $error("divided clock not on clock output 0");

endmodule

// file: phm_pin_model.sv
`timescale 1ns/1ps
module phm_pin_model
(
  // Clock
  input  wire logic        clk_i,
  // Block side of the pads
  input  wire logic [10:0] pin_out_i,
  input  wire logic [10:0] pin_oe_n_i,
  input  wire logic [10:0] pin_pullup_off_i,
  // External drivers
  input  wire logic [10:0] ext_i,
  input  wire logic [10:0] ext_en_i,
  // Resolved pad level
  output logic      [10:0] level_o
);
  logic [10:0] float_r;

  // Undriven pad without pull-up wanders every cycle
  always @(posedge clk_i)
  begin
    float_r <= ~float_r;
  end

  initial float_r = 11'h2AA;

  // Block drive wins, then external drive, then pull-up; all 11 pins resolved alike
  always_comb
  begin
    for (int i = 0; i < 11; i++)
    begin
      if (!pin_oe_n_i[i])
        level_o[i] = pin_out_i[i];
      else if (ext_en_i[i])
        level_o[i] = ext_i[i];
      else
        level_o[i] = pin_pullup_off_i[i] ? float_r[i] : 1'b1;
    end
  end
endmodule

// file: port_h_misc_dclk_control_test.sv
`timescale 1ns/1ps
`include "phm_cfg.svh"
module port_h_misc_dclk_control_test;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
  logic [31:0] adr_i, dat_i, dat_o, q;
  logic [3:0]  sel_i;
  logic [10:0] pin_in_i, pin_out_o, pin_oe_n_o, pin_pullup_off_o, ext, ext_en;
  logic        serial0_transmit_i, serial1_transmit_i, serial2_transmit_i;
  logic        serial0_request_to_send_i, serial1_request_to_send_i;
  logic        serial0_receive_o, serial1_receive_o, serial2_receive_o;
  logic        serial0_clear_to_send_o, serial1_clear_to_send_o, serial_external_clock_o;
  logic        main_pll_i, usb_pll_i, core_clock_i, bus_clock_i, usb_clock_i;
  logic        mem_clock_i, mem_clock_enable_i, usb_run;
  logic        mem_clock0_out_o, mem_clock1_out_o, mem_clock_enable_out_o;
  logic        external_reset_out_o, usb_port0_suspend_o, usb_port1_suspend_o;
  logic        usb_pad_owner_sel_o, data_low_pullup_off_o, data_high_pullup_off_o;
  logic [8:0]  misc_v;
  logic [3:0]  rx_v;
  int          fail_count, check_count, hi, rs;

  assign misc_v = {mem_clock_enable_out_o, mem_clock1_out_o, mem_clock0_out_o,
                   external_reset_out_o, usb_port1_suspend_o, usb_port0_suspend_o,
                   usb_pad_owner_sel_o, data_low_pullup_off_o, data_high_pullup_off_o};
  assign rx_v = {serial2_receive_o, serial1_receive_o, serial0_receive_o,
                 serial0_clear_to_send_o};

  phm_port_misc u_dut
  (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
    .pin_in_i, .pin_out_o, .pin_oe_n_o, .pin_pullup_off_o,
    .serial0_transmit_i, .serial1_transmit_i, .serial2_transmit_i,
    .serial0_request_to_send_i, .serial1_request_to_send_i,
    .serial0_receive_o, .serial1_receive_o, .serial2_receive_o,
    .serial0_clear_to_send_o, .serial1_clear_to_send_o, .serial_external_clock_o,
    .main_pll_i, .usb_pll_i, .core_clock_i, .bus_clock_i, .usb_clock_i,
    .mem_clock_i, .mem_clock_enable_i, .mem_clock0_out_o, .mem_clock1_out_o,
    .mem_clock_enable_out_o, .external_reset_out_o, .usb_port0_suspend_o,
    .usb_port1_suspend_o, .usb_pad_owner_sel_o, .data_low_pullup_off_o,
    .data_high_pullup_off_o
  );

  phm_pin_model u_pins
  (
    .clk_i(clk_i), .pin_out_i(pin_out_o), .pin_oe_n_i(pin_oe_n_o),
    .pin_pullup_off_i(pin_pullup_off_o), .ext_i(ext), .ext_en_i(ext_en), .level_o(pin_in_i)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // USB clock runs at half the bus clock while enabled
  always @(posedge clk_i)
  begin
    if (usb_run)
      usb_clock_i <= !usb_clock_i;
  end

  task automatic conclude();
    if (fail_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask

  // Classic single cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && n < 50);
    if (n >= 50)
      fail_count++;
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000);
    chk(q, e);
  endtask

  // Counts high samples and rising edges of one pin over 40 cycles
  task automatic meas(input int p);
    logic prev;
    hi = 0;
    rs = 0;
    repeat (8) @(posedge clk_i);
    prev = pin_out_o[p];
    repeat (40)
    begin
      @(posedge clk_i);
      hi += pin_out_o[p];
      rs += (pin_out_o[p] && !prev);
      prev = pin_out_o[p];
    end
  endtask

  task automatic t_reset();
    rd(`PHM_ADDR_ROLE, 32'h0000_0000);
    rd(`PHM_ADDR_PULL, 32'h0000_0000);
    rd(`PHM_ADDR_MISC, 32'h0001_0330);
    rd(`PHM_ADDR_DCLK, 32'h0000_0000);
    rd(`PHM_ADDR_RSVD, 32'h0000_0000);
    chk(misc_v, 9'h1E0);
  endtask

  task automatic t_gpio();
    wb(1'b1, `PHM_ADDR_ROLE, 32'h0015_5555);
    wb(1'b1, `PHM_ADDR_DATA, 32'h0000_05A5);
    repeat (4) @(posedge clk_i);
    chk(pin_out_o, 11'h5A5);
    chk(pin_oe_n_o, 11'h000);
    rd(`PHM_ADDR_DATA, 32'h0000_05A5);
    ext_en <= 11'h7FF;
    ext <= 11'h2C3;
    wb(1'b1, `PHM_ADDR_ROLE, 32'h0000_0000);
    repeat (4) @(posedge clk_i);
    rd(`PHM_ADDR_DATA, 32'h0000_02C3);
    chk(pin_oe_n_o, 11'h7FF);
    wb(1'b1, `PHM_ADDR_PULL, 32'h0000_0531);
    repeat (2) @(posedge clk_i);
    rd(`PHM_ADDR_PULL, 32'h0000_0531);
    chk(pin_pullup_off_o, 11'h531);
  endtask

  task automatic t_misc();
    wb(1'b1, `PHM_ADDR_MISC, 32'h000E_300B);
    repeat (2) @(posedge clk_i);
    chk(misc_v, 9'h01F);
    rd(`PHM_ADDR_MISC, 32'h000E_300B);
    wb(1'b1, `PHM_ADDR_MISC, 32'h0001_0330);
    repeat (2) @(posedge clk_i);
    chk(misc_v, 9'h1E0);
  endtask

  task automatic t_alt();
    ext <= 11'h100;
    serial1_request_to_send_i <= 1'b1;
    wb(1'b1, `PHM_ADDR_ROLE, 32'h0002_F000);
    repeat (6) @(posedge clk_i);
    chk({serial_external_clock_o, serial1_clear_to_send_o}, 2'h2);
    chk({pin_oe_n_o[6], pin_out_o[6]}, 2'h1);
    serial0_transmit_i <= 1'b1;
    serial2_transmit_i <= 1'b1;
    serial0_request_to_send_i <= 1'b1;
    ext <= 11'h0A8;
    wb(1'b1, `PHM_ADDR_ROLE, 32'h0000_AAAA);
    repeat (6) @(posedge clk_i);
    chk(pin_out_o & 11'h056, 11'h046);
    chk(rx_v, 4'hE);
    ext <= 11'h001;
    repeat (6) @(posedge clk_i);
    chk(rx_v, 4'h1);
  endtask

  task automatic t_clock();
    // Compare value kept below divide value
    wb(1'b1, `PHM_ADDR_ROLE, 32'h0028_0000);
    for (int k = 0; k < 5; k++)
    begin
      wb(1'b1, `PHM_ADDR_MISC, 32'h0001_0000 | (k << 4));
      meas(9);
      chk(hi, (k == 4) ? 20 : (k[0] ? 0 : 40));
      chk(rs, (k == 4) ? 20 : 0);
    end
    wb(1'b1, `PHM_ADDR_MISC, 32'h0001_0350);
    wb(1'b1, `PHM_ADDR_DCLK, 32'h0000_0041);
    meas(9);
    chk(hi, 32);
    chk(rs, 8);
    wb(1'b1, `PHM_ADDR_DCLK, 32'h0000_0241);
    meas(9);
    chk(hi, 16);
    chk(rs, 8);
    wb(1'b1, `PHM_ADDR_DCLK, 32'h0000_0240);
    meas(9);
    chk(hi, 0);
    chk(rs, 0);
    wb(1'b1, `PHM_ADDR_DCLK, 32'h0000_0243);
    meas(9);
    chk(rs, 0);
    usb_run <= 1'b1;
    meas(9);
    chk(hi, 16);
    chk(rs, 4);
    usb_run <= 1'b0;
    wb(1'b1, `PHM_ADDR_DCLK, 32'h0041_0241);
    wb(1'b1, `PHM_ADDR_MISC, 32'h0001_0530);
    meas(9);
    chk(hi, 0);
    chk(rs, 0);
    meas(10);
    chk(hi, 32);
    chk(rs, 8);
  endtask

  initial
  begin
    fail_count = 0;
    check_count = 0;
    rst_i = 1'b1;
    {cyc_i, stb_i, we_i, sel_i, adr_i, dat_i} = '0;
    sel_i = 4'hF;
    ext = 11'h000;
    ext_en = 11'h000;
    {serial0_transmit_i, serial1_transmit_i, serial2_transmit_i} = 3'h0;
    {serial0_request_to_send_i, serial1_request_to_send_i} = 2'h0;
    {main_pll_i, usb_pll_i, core_clock_i, bus_clock_i, usb_clock_i} = 5'h14;
    mem_clock_i = 1'b1;
    mem_clock_enable_i = 1'b1;
    usb_run = 1'b0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_gpio();
    t_misc();
    t_alt();
    t_clock();
    conclude();
  end

  initial
  begin
    #100000;
    fail_count++;
    conclude();
  end
endmodule
